// *** hdl/cfg_loader_defs.svh ***
// What this block does
// - load eeprom into registers after reset, unprompted
// - two-wire bus master drives clock, addresses memory
// - target accesses get retry while load runs
// - byte 00 latency/grant into field 3Eh
// - vendor bytes 01-02, subsystem 03-04 loaded
// - bytes 07-0A lsb first into 24h
// - bytes 0B-0E lsb first into 28h
// - byte 05 bits 7,2,1 into enhancement control, bit 6 into phy programming enable
`ifndef CFG_LOADER_DEFS_SVH
`define CFG_LOADER_DEFS_SVH

// configuration space byte offsets
`define OFS_UID_UPPER 8'h24
`define OFS_UID_LOWER 8'h28
`define OFS_SUBSYS_ID 8'h2C
`define OFS_VENDOR_ID 8'h2D
`define OFS_LAT_GNT 8'h3E
`define OFS_HOST_CTRL_CFG 8'h40
`define OFS_HOST_CONTROL 8'h50
`define OFS_MISC_CONFIG 8'hF0
`define OFS_LINK_TUNING 8'hF4

// eeprom byte addresses
`define EE_LAT_GNT 5'h00
`define EE_VENDOR_LO 5'h01
`define EE_VENDOR_HI 5'h02
`define EE_SUBSYS_LO 5'h03
`define EE_SUBSYS_HI 5'h04
`define EE_LINK_BITS 5'h05
`define EE_MINI_ROM 5'h06
`define EE_UID_UPPER 5'h07
`define EE_UID_LOWER 5'h0B
`define EE_UID_END 5'h0F
`define EE_CTRL_10 5'h10
`define EE_CTRL_11 5'h11
`define EE_CTRL_12 5'h12
`define EE_CTRL_13 5'h13
`define EE_CIS 5'h14
`define EE_LAST 5'h14
`define EE_FIRST_WORD_ADDR 8'h00

// memory select bytes on the two-wire bus
`define EE_SELECT_WRITE 8'hA0
`define EE_SELECT_READ 8'hA1

// bits the load may touch, host may rewrite
`define HC_RELOAD_BIT 31
`define HC_PHY_PROG_BIT 23
`define HOST_CTRL_MASK 32'h0080_0000
`define LINK_TUNING_MASK 32'h0000_3386
`define MISC_CONFIG_MASK 32'h0000_A43F
`define HOST_CTRL_CFG_MASK 32'h0000_0001

// two-wire clock timing, quarter of a bit period
`define CLOCK_PERIOD_NS 10
`define SCL_QUARTER_NS 2500
`define SCL_QUARTER_CYCLES ((`SCL_QUARTER_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

// *** hdl/cfg_loader_pkg.sv ***
`default_nettype none
package cfg_loader_pkg;
   // bus condition or byte the engine performs
   typedef enum logic [1:0] {OP_START = 2'b00, OP_STOP = 2'b01, OP_WRITE = 2'b10,
                             OP_READ = 2'b11} wire_op_e;
   // engine activity
   typedef enum logic [1:0] {ENG_IDLE = 2'b00, ENG_START = 2'b01, ENG_STOP = 2'b10,
                             ENG_XFER = 2'b11} eng_state_e;
   // loader sequence
   typedef enum logic [2:0] {LD_START1 = 3'b000, LD_SEL_W = 3'b001, LD_WADDR = 3'b010,
                             LD_START2 = 3'b011, LD_SEL_R = 3'b100, LD_READ = 3'b101,
                             LD_STOP = 3'b110, LD_IDLE = 3'b111} ld_state_e;
endpackage : cfg_loader_pkg
`default_nettype wire

// *** hdl/two_wire_engine.sv ***
`include "cfg_loader_defs.svh"
`default_nettype none
module two_wire_engine #(
   parameter int QUARTER_CYCLES = `SCL_QUARTER_CYCLES
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic cmd_valid,
   input wire cfg_loader_pkg::wire_op_e cmd_op,
   input wire logic [7:0] cmd_byte,
   input wire logic cmd_nack,
   input wire logic sda_level,
   output logic busy,
   output logic done,
   output logic [7:0] rx_byte,
   output logic rx_nack,
   output logic sda_low,
   output logic scl_low
);
   import cfg_loader_pkg::*;

   eng_state_e state_r; // current condition or transfer
   logic [15:0] tick_r; // cycles within a quarter
   logic [1:0] quarter_r; // quarter of the bit period
   logic [3:0] bit_cnt_r; // bit within a nine-bit transfer
   logic [8:0] shift_r; // bits to put on the data line
   logic [8:0] rx_r; // bits seen on the data line
   logic done_r;
   logic sda_low_r;
   logic scl_low_r;

   wire quarter_end = (tick_r == 16'(QUARTER_CYCLES - 1));
   wire last_quarter = quarter_end && (quarter_r == 2'h3);
   wire bits_over = (bit_cnt_r == 4'h8);
   // data line drive per condition and quarter
   wire sda_low_nxt = (state_r == ENG_START) ? (quarter_r[1]) :
                      (state_r == ENG_STOP) ? (~quarter_r[1]) :
                      (state_r == ENG_XFER) ? ~shift_r[8] : sda_low_r;
   // clock line: high in quarters 1 and 2, start keeps level in quarter 0
   wire scl_mid = (quarter_r == 2'h1) || (quarter_r == 2'h2);
   wire scl_low_nxt = (state_r == ENG_IDLE) ? scl_low_r :
                      (state_r == ENG_START && quarter_r == 2'h0) ? scl_low_r :
                      (state_r == ENG_STOP && quarter_r[1]) ? 1'b0 : ~scl_mid;

   // sequencing of quarters and bits
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_r <= ENG_IDLE;
         tick_r <= 16'h0000;
         quarter_r <= 2'h0;
         bit_cnt_r <= 4'h0;
         shift_r <= 9'h1FF;
         rx_r <= 9'h000;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (state_r == ENG_IDLE) begin
            tick_r <= 16'h0000;
            quarter_r <= 2'h0;
            bit_cnt_r <= 4'h0;
            if (cmd_valid) begin
               // read releases data and sends its own acknowledge bit
               shift_r <= (cmd_op == OP_READ) ? {8'hFF, cmd_nack} : {cmd_byte, 1'b1};
               state_r <= (cmd_op == OP_START) ? ENG_START :
                          (cmd_op == OP_STOP) ? ENG_STOP : ENG_XFER;
            end
         end else begin
            tick_r <= quarter_end ? 16'h0000 : tick_r + 16'h0001;
            if (quarter_end) begin
               quarter_r <= quarter_r + 2'h1;
            end
            // sample at the end of the clock-high time
            if (state_r == ENG_XFER && quarter_end && quarter_r == 2'h2) begin
               rx_r <= {rx_r[7:0], sda_level};
            end
            if (last_quarter) begin
               shift_r <= {shift_r[7:0], 1'b1};
               bit_cnt_r <= bit_cnt_r + 4'h1;
               if (state_r != ENG_XFER || bits_over) begin
                  state_r <= ENG_IDLE;
                  done_r <= 1'b1;
               end
            end
         end
      end
   end

   // line drive registered so pins never glitch
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sda_low_r <= 1'b0;
         scl_low_r <= 1'b0;
      end else begin
         sda_low_r <= sda_low_nxt;
         scl_low_r <= scl_low_nxt;
      end
   end

   assign busy = (state_r != ENG_IDLE);
   assign done = done_r;
   assign rx_byte = rx_r[8:1];
   assign rx_nack = rx_r[0];
   assign sda_low = sda_low_r;
   assign scl_low = scl_low_r;
endmodule : two_wire_engine
`default_nettype wire

// *** hdl/cfg_loader.sv ***
`include "cfg_loader_defs.svh"
`default_nettype none
module cfg_loader #(
   parameter int QUARTER_CYCLES = `SCL_QUARTER_CYCLES
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic scl_out,
   output logic scl_oe,
   input wire logic access_req,
   input wire logic access_write,
   input wire logic [7:0] access_addr,
   input wire logic [31:0] access_wdata,
   output logic access_done,
   output logic access_retry,
   output logic [31:0] access_rdata,
   output logic load_active,
   output logic load_failed,
   output logic [7:0] mini_rom_addr,
   output logic [7:0] cis_offset
);
   import cfg_loader_pkg::*;

   // merge one loaded byte into the masked bits of a register lane
   function automatic logic [31:0] merge_lane(input logic [31:0] cur, input logic [31:0] mask,
                                              input logic [1:0] lane, input logic [7:0] data);
      logic [31:0] wide;
      logic [31:0] lane_mask;
      wide = {24'h000000, data} << {lane, 3'b000};
      lane_mask = mask & (32'h0000_00FF << {lane, 3'b000});
      merge_lane = (cur & ~lane_mask) | (wide & lane_mask);
   endfunction : merge_lane

   // data pin synchroniser, first stage read only by the second
   logic sda_meta_r;
   logic sda_sync_r;

   // loader sequence
   ld_state_e state_r;
   logic wait_r; // a command is out at the engine
   logic cmd_valid_r; // one-cycle command strobe
   logic [4:0] idx_r; // eeprom byte being read
   logic loading_r;
   logic failed_r;

   // loaded registers
   logic [31:0] uid_upper_r;
   logic [31:0] uid_lower_r;
   logic [15:0] subsys_r;
   logic [15:0] vendor_r;
   logic [15:0] lat_gnt_r;
   logic [31:0] host_ctrl_cfg_r;
   logic [31:0] host_control_r;
   logic [31:0] misc_config_r;
   logic [31:0] link_tuning_r;
   logic [7:0] mini_rom_r;
   logic [7:0] cis_r;

   // target answer
   logic done_r;
   logic retry_r;
   logic [31:0] rdata_r;

   // engine handshake
   logic eng_busy;
   logic eng_done;
   logic [7:0] eng_rx;
   logic eng_nack;
   logic eng_sda_low;
   logic eng_scl_low;

   // engine command chosen by the sequence state
   wire wire_op_e cmd_op = (state_r == LD_START1 || state_r == LD_START2) ? OP_START :
                           (state_r == LD_READ) ? OP_READ :
                           (state_r == LD_STOP) ? OP_STOP : OP_WRITE;
   wire [7:0] cmd_byte = (state_r == LD_SEL_W) ? `EE_SELECT_WRITE :
                         (state_r == LD_SEL_R) ? `EE_SELECT_READ : `EE_FIRST_WORD_ADDR;
   wire last_byte = (idx_r == `EE_LAST);
   wire issue = (state_r != LD_IDLE) && !wait_r && !cmd_valid_r && !eng_busy;
   wire step = eng_done && wait_r;
   wire sel_nack = step && eng_nack &&
                   (state_r == LD_SEL_W || state_r == LD_WADDR || state_r == LD_SEL_R);
   wire byte_in = step && (state_r == LD_READ);

   // target access decode
   wire acc_rd = access_req && !access_write && !loading_r;
   wire acc_wr = access_req && access_write && !loading_r;
   wire hit_host_control = (access_addr == `OFS_HOST_CONTROL);
   wire reload_req = acc_wr && hit_host_control && access_wdata[`HC_RELOAD_BIT];
   wire wr_host_control = acc_wr && hit_host_control;
   wire wr_host_ctrl_cfg = acc_wr && (access_addr == `OFS_HOST_CTRL_CFG);
   wire wr_misc_config = acc_wr && (access_addr == `OFS_MISC_CONFIG);
   wire wr_link_tuning = acc_wr && (access_addr == `OFS_LINK_TUNING);
   wire [31:0] rd_mux =
      (access_addr == `OFS_UID_UPPER) ? uid_upper_r :
      (access_addr == `OFS_UID_LOWER) ? uid_lower_r :
      (access_addr == `OFS_SUBSYS_ID) ? {16'h0000, subsys_r} :
      (access_addr == `OFS_VENDOR_ID) ? {16'h0000, vendor_r} :
      (access_addr == `OFS_LAT_GNT) ? {16'h0000, lat_gnt_r} :
      (access_addr == `OFS_HOST_CTRL_CFG) ? host_ctrl_cfg_r :
      (access_addr == `OFS_HOST_CONTROL) ? host_control_r :
      (access_addr == `OFS_MISC_CONFIG) ? misc_config_r :
      (access_addr == `OFS_LINK_TUNING) ? link_tuning_r : 32'h0000_0000;

   // byte routing during the load
   wire [1:0] uid_lane = 2'(idx_r - `EE_UID_UPPER);
   wire [1:0] uid_lane_lo = 2'(idx_r - `EE_UID_LOWER);
   wire in_uid_upper = (idx_r >= `EE_UID_UPPER) && (idx_r < `EE_UID_LOWER);
   wire in_uid_lower = (idx_r >= `EE_UID_LOWER) && (idx_r < `EE_UID_END);

   // two flops before the data level is used
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sda_meta_r <= 1'b1;
         sda_sync_r <= 1'b1;
      end else begin
         sda_meta_r <= sda_in;
         sda_sync_r <= sda_meta_r;
      end
   end

   // load sequence: start, select, word address, restart, select, reads, stop
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_r <= LD_START1;
         loading_r <= 1'b1;
         failed_r <= 1'b0;
         wait_r <= 1'b0;
         cmd_valid_r <= 1'b0;
         idx_r <= 5'h00;
      end else begin
         cmd_valid_r <= issue;
         if (issue) begin
            wait_r <= 1'b1;
         end else if (step) begin
            wait_r <= 1'b0;
         end
         if (sel_nack) begin
            // memory absent or busy: give up, registers keep what they hold
            state_r <= LD_STOP;
            failed_r <= 1'b1;
         end else if (step) begin
            unique case (state_r)
               LD_START1: state_r <= LD_SEL_W;
               LD_SEL_W: state_r <= LD_WADDR;
               LD_WADDR: state_r <= LD_START2;
               LD_START2: state_r <= LD_SEL_R;
               LD_SEL_R: state_r <= LD_READ;
               LD_READ: begin
                  // reserved tail bytes are never fetched
                  state_r <= last_byte ? LD_STOP : LD_READ;
                  idx_r <= idx_r + 5'h01;
               end
               LD_STOP: begin
                  state_r <= LD_IDLE;
                  loading_r <= 1'b0;
               end
               LD_IDLE: state_r <= LD_IDLE;
            endcase
         end else if (state_r == LD_IDLE && reload_req) begin
            // software-requested reload repeats the power-up sequence
            state_r <= LD_START1;
            loading_r <= 1'b1;
            failed_r <= 1'b0;
            idx_r <= 5'h00;
         end
      end
   end

   // loaded identifier and configuration words
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         uid_upper_r <= 32'h0000_0000;
         uid_lower_r <= 32'h0000_0000;
         subsys_r <= 16'h0000;
         vendor_r <= 16'h0000;
         lat_gnt_r <= 16'h0000;
         mini_rom_r <= 8'h00;
         cis_r <= 8'h00;
      end else if (byte_in) begin
         if (in_uid_upper) begin
            uid_upper_r[{uid_lane, 3'b000} +: 8] <= eng_rx;
         end
         if (in_uid_lower) begin
            uid_lower_r[{uid_lane_lo, 3'b000} +: 8] <= eng_rx;
         end
         if (idx_r == `EE_LAT_GNT) begin
            lat_gnt_r <= {4'h0, eng_rx[7:4], 4'h0, eng_rx[3:0]};
         end
         if (idx_r == `EE_VENDOR_LO) begin
            vendor_r[7:0] <= eng_rx;
         end
         if (idx_r == `EE_VENDOR_HI) begin
            vendor_r[15:8] <= eng_rx;
         end
         if (idx_r == `EE_SUBSYS_LO) begin
            subsys_r[7:0] <= eng_rx;
         end
         if (idx_r == `EE_SUBSYS_HI) begin
            subsys_r[15:8] <= eng_rx;
         end
         if (idx_r == `EE_MINI_ROM) begin
            mini_rom_r <= eng_rx;
         end
         if (idx_r == `EE_CIS) begin
            cis_r <= eng_rx;
         end
      end
   end

   // control registers: loaded bits, host may rewrite the same bits later
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         host_ctrl_cfg_r <= 32'h0000_0000;
         host_control_r <= 32'h0000_0000;
         misc_config_r <= 32'h0000_0000;
         link_tuning_r <= 32'h0000_0000;
      end else if (byte_in) begin
         if (idx_r == `EE_LINK_BITS) begin
            // bit 6 goes to the phy programming enable, bits 7, 2 and 1 stay in lane 0
            link_tuning_r <= merge_lane(link_tuning_r, `LINK_TUNING_MASK, 2'h0, eng_rx);
            host_control_r[`HC_PHY_PROG_BIT] <= eng_rx[6];
         end
         if (idx_r == `EE_CTRL_10) begin
            link_tuning_r <= merge_lane(link_tuning_r, `LINK_TUNING_MASK, 2'h1, eng_rx);
         end
         if (idx_r == `EE_CTRL_11) begin
            misc_config_r <= merge_lane(misc_config_r, `MISC_CONFIG_MASK, 2'h0, eng_rx);
         end
         if (idx_r == `EE_CTRL_12) begin
            misc_config_r <= merge_lane(misc_config_r, `MISC_CONFIG_MASK, 2'h1, eng_rx);
         end
         if (idx_r == `EE_CTRL_13) begin
            host_ctrl_cfg_r <= merge_lane(host_ctrl_cfg_r, `HOST_CTRL_CFG_MASK, 2'h0,
                                          eng_rx);
         end
      end else begin
         // host writes reach only the loadable bits; the reload bit is not stored
         if (wr_host_control) begin
            host_control_r <= access_wdata & `HOST_CTRL_MASK;
         end
         if (wr_host_ctrl_cfg) begin
            host_ctrl_cfg_r <= access_wdata & `HOST_CTRL_CFG_MASK;
         end
         if (wr_misc_config) begin
            misc_config_r <= access_wdata & `MISC_CONFIG_MASK;
         end
         if (wr_link_tuning) begin
            link_tuning_r <= access_wdata & `LINK_TUNING_MASK;
         end
      end
   end

   // target answer one cycle after the request
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         done_r <= 1'b0;
         retry_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else begin
         retry_r <= access_req && loading_r;
         done_r <= access_req && !loading_r;
         if (acc_rd) begin
            rdata_r <= rd_mux;
         end
      end
   end

   // bit-level engine; the loader is its only client
   two_wire_engine #(
      .QUARTER_CYCLES(QUARTER_CYCLES)
   ) engine (
      .clock(clock),
      .reset(reset),
      .cmd_valid(cmd_valid_r),
      .cmd_op(cmd_op),
      .cmd_byte(cmd_byte),
      .cmd_nack(last_byte),
      .sda_level(sda_sync_r),
      .busy(eng_busy),
      .done(eng_done),
      .rx_byte(eng_rx),
      .rx_nack(eng_nack),
      .sda_low(eng_sda_low),
      .scl_low(eng_scl_low)
   );

   // open-drain pins: only ever pull low
   assign sda_out = 1'b0;
   assign scl_out = 1'b0;
   assign sda_oe = eng_sda_low;
   assign scl_oe = eng_scl_low;
   assign access_done = done_r;
   assign access_retry = retry_r;
   assign access_rdata = rdata_r;
   assign load_active = loading_r;
   assign load_failed = failed_r;
   assign mini_rom_addr = mini_rom_r;
   assign cis_offset = cis_r;
endmodule : cfg_loader
`default_nettype wire

// *** dv/cfg_loader_sva.sv ***
`default_nettype none
module cfg_loader_sva #(
   parameter int QUARTER_CYCLES = 4
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic access_req,
   input wire logic access_done,
   input wire logic access_retry,
   input wire logic [31:0] access_rdata,
   input wire logic load_active,
   input wire logic load_failed
);
   timeunit 1ns;
   timeprecision 1ps;
   // single domain, so one clock and one disable for all
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // loading: every request refused one cycle later
   retry_while_load_a: assert property (access_req && load_active |=>
      access_retry && !access_done)
      else $error("request during load not retried");
   // idle: request completes one cycle later
   done_when_idle_a: assert property (access_req && !load_active |=>
      access_done && !access_retry)
      else $error("request after load not completed");
   // no answer without a request
   no_lone_answer_a: assert property (!access_req |=> !access_done && !access_retry)
      else $error("answer without request");
   // a refused access leaves read data alone
   retry_keeps_data_a: assert property (access_retry |-> $stable(access_rdata))
      else $error("read data moved on retry");
   // read data moves only with a completed access
   data_on_done_a: assert property ($changed(access_rdata) |-> access_done)
      else $error("read data moved without done");
   // open drain: pins only ever pulled low
   open_drain_a: assert property (sda_out == 1'b0 && scl_out == 1'b0)
      else $error("two-wire pin driven high");
   // bus left released once the load is over
   bus_idle_a: assert property (!load_active |-> !scl_oe && !sda_oe)
      else $error("two-wire bus busy outside load");
   // clock low phase lasts at least one quarter
   clock_low_a: assert property ($rose(scl_oe) |-> scl_oe [*4])
      else $error("two-wire clock low too short");
   // clock high phase spans two quarters
   clock_high_a: assert property ($fell(scl_oe) |-> (!scl_oe) [*8])
      else $error("two-wire clock high too short");
   // a refused select ends the load soon after the stop
   fail_ends_load_a: assert property ($rose(load_failed) |-> ##[0:40] !load_active)
      else $error("failed load did not end");
   cover property (access_retry);
   cover property (access_done);
   cover property ($fell(load_active));
   cover property ($rose(load_failed));
endmodule : cfg_loader_sva
`default_nettype wire

// *** dv/eeprom_model.sv ***
`default_nettype none
module eeprom_model (
   input wire logic scl,
   input wire logic sda,
   input wire logic nack_en,
   output logic sda_low
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [32]; // contents, filled by the bench
   logic [7:0] sh = 8'h00; // received byte
   logic [4:0] ptr = 5'h00; // read address
   logic rd = 1'b0; // sending to the master
   logic go_rd = 1'b0; // read select accepted
   logic sel = 1'b0; // next byte is a select byte
   logic waddr = 1'b0; // next byte is a word address
   int cnt = 0; // bit within byte, 8 is the ack slot
   initial sda_low = 1'b0;
   // start or stop: data moves while the clock is high
   always @(sda) begin
      if (scl === 1'b1) begin
         sel = !sda;
         rd = 1'b0;
         cnt = 0;
         sda_low = 1'b0;
      end
   end
   // bits taken on the rising clock
   always @(posedge scl) begin
      if (cnt < 8 && !rd) sh = {sh[6:0], sda};
      if (cnt == 8) begin
         if (rd) ptr = ptr + 5'd1;
         rd = rd ? !sda : go_rd; // master nack ends the read
         go_rd = 1'b0;
      end
      cnt = (cnt == 8) ? 0 : cnt + 1;
   end
   // drive only while the clock is low, so no false start or stop
   always @(negedge scl) begin
      if (cnt == 8 && !rd && sel) begin
         sda_low = (sh[7:1] == 7'h50) && !nack_en;
         go_rd = sda_low && sh[0];
         waddr = sda_low && !sh[0];
         sel = 1'b0;
      end else if (cnt == 8 && !rd) begin
         if (waddr) ptr = sh[4:0];
         waddr = 1'b0;
         sda_low = 1'b1;
      end else begin
         sda_low = rd && cnt < 8 && !mem[ptr][7 - cnt];
      end
   end
endmodule : eeprom_model
`default_nettype wire

// *** dv/tb_top.sv ***
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int QC = 4; // short quarter keeps each load brief
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic access_req = 1'b0;
   logic access_write = 1'b0;
   logic nack_en = 1'b0; // memory refuses its select byte
   logic [7:0] access_addr = 8'h00;
   logic [31:0] access_wdata = 32'h0;
   logic sda_out, sda_oe, scl_out, scl_oe, access_done, access_retry;
   logic load_active, load_failed;
   logic [31:0] access_rdata, q, d;
   logic [7:0] mini_rom_addr, cis_offset;
   logic [7:0] m [32]; // memory image
   logic [31:0] ex [int]; // expected register values by offset
   logic [31:0] seed = 32'hF34BDE01;
   int n_fail = 0;
   int checked = 0;
   wire logic mem_low;
   // pull-ups: a line is high unless someone pulls it low
   wire logic scl_line = !scl_oe;
   wire logic sda_line = !(sda_oe || mem_low);
   always #5 clock = ~clock;
   cfg_loader #(.QUARTER_CYCLES(QC)) i_dut (.clock(clock), .reset(reset), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe),
      .access_req(access_req), .access_write(access_write), .access_addr(access_addr),
      .access_wdata(access_wdata), .access_done(access_done), .access_retry(access_retry),
      .access_rdata(access_rdata), .load_active(load_active), .load_failed(load_failed),
      .mini_rom_addr(mini_rom_addr), .cis_offset(cis_offset));
   eeprom_model i_mem (.scl(scl_line), .sda(sda_line), .nack_en(nack_en), .sda_low(mem_low));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_data
   task automatic chk_flag(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_flag
   // new memory image and the registers it should produce
   task automatic fill();
      for (int k = 0; k < 32; k++) begin
         m[k] = 8'(xs());
         i_mem.mem[k] = m[k];
      end
      ex[8'h24] = {m[10], m[9], m[8], m[7]};
      ex[8'h28] = {m[14], m[13], m[12], m[11]};
      ex[8'h2C] = {16'h0, m[4], m[3]};
      ex[8'h2D] = {16'h0, m[2], m[1]};
      ex[8'h3E] = {20'h0, m[0][7:4], 4'h0, m[0][3:0]};
      ex[8'h40] = {31'h0, m[19][0]};
      ex[8'h50] = {8'h0, m[5][6], 23'h0};
      ex[8'hF0] = {16'h0, m[18], m[17]} & 32'h0000A43F;
      ex[8'hF4] = {16'h0, m[16], m[5]} & 32'h00003386;
   endtask : fill
   // one access; answer expected exactly one cycle after it is taken
   task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      input logic busy);
      @(posedge clock);
      access_req <= 1'b1;
      access_write <= wr;
      access_addr <= a;
      access_wdata <= wd;
      @(posedge clock);
      access_req <= 1'b0;
      #1;
      chk_flag(access_retry, busy);
      chk_flag(access_done, !busy);
      q = access_rdata;
   endtask : acc
   task automatic wait_load();
      int n;
      n = 0;
      while (load_active !== 1'b0 && n < 20000) begin
         @(posedge clock);
         n++;
      end
      chk_flag(load_active, 1'b0);
   endtask : wait_load
   task automatic check_all();
      foreach (ex[a]) begin
         acc(1'b0, a[7:0], xs(), 1'b0);
         chk_data(q, ex[a]);
      end
      chk_data(mini_rom_addr, m[6]);
      chk_data(cis_offset, m[20]);
   endtask : check_all
   // restart the load from the host side
   task automatic reload();
      d = ex[8'h50] | 32'h80000000;
      acc(1'b1, 8'h50, d, 1'b0);
      @(posedge clock);
      #1;
      chk_flag(load_active, 1'b1);
   endtask : reload
   task automatic results();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results
   initial begin
      fill();
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      // alternating reads and writes while loading, one idle cycle between requests
      for (int k = 0; k < 4; k++) begin
         acc(k[0], 8'hF4, xs(), 1'b1);
         chk_data(q, 32'h0);
      end
      wait_load();
      chk_flag(load_failed, 1'b0);
      check_all();
      $display("power-up load test done");
      // host writes: masked tuning bits, read-only id; read of an unmapped offset
      d = xs();
      acc(1'b1, 8'hF4, d, 1'b0);
      ex[8'hF4] = d & 32'h00003386;
      acc(1'b1, 8'h24, xs(), 1'b0);
      acc(1'b0, 8'h30, xs(), 1'b0);
      chk_data(q, 32'h0);
      check_all();
      $display("host access test done");
      // second image, load restarted, reads refused meanwhile
      fill();
      reload();
      acc(1'b0, 8'h28, xs(), 1'b1);
      wait_load();
      check_all();
      $display("reload test done");
      // memory refuses: old values stay, failure flagged
      nack_en <= 1'b1;
      reload();
      wait_load();
      chk_flag(load_failed, 1'b1);
      check_all();
      nack_en <= 1'b0;
      $display("refused load test done");
      results();
   end
   // watchdog: loads take a few thousand cycles each
   initial begin
      #500000;
      n_fail++;
      results();
   end
endmodule : tb_top
bind cfg_loader cfg_loader_sva #(.QUARTER_CYCLES(QUARTER_CYCLES)) i_sva (.clock(clock),
   .reset(reset), .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe),
   .access_req(access_req), .access_done(access_done), .access_retry(access_retry),
   .access_rdata(access_rdata), .load_active(load_active), .load_failed(load_failed));
`default_nettype wire
